// *** bench/tcfp_tb.sv ***
// Self-checking bench for the timer CLEAR_ON_MATCH_MODE and fast PWM block.
`timescale 1ns/1ps
module tcfp_tb;
  import tcfp_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  aw = 8'h00;
  logic [7:0]  ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv, pa, pa_oe, pb, pb_oe;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdat, v, c;
  int          n_mismatch = 0, checked = 0, hi, lo, e;
  always #50 mclk = ~mclk;
  tcfp_top u_dut (
    .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .wave_out_a(pa),
    .wave_out_a_oe(pa_oe), .wave_out_b(pb), .wave_out_b_oe(pb_oe)
  );
  // ========================================
  // Bus tasks and helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Ready for the response is raised only once both address and data are taken.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(posedge mclk);
      if (br && bv) break;
      if (awr && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wr_rdy && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
      if (ad && dd) br <= 1'b1;
    end
    br <= 1'b0;
    check("bresp", bresp, er);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
    ar <= a;
    arv <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rr && rv) break;
      if (arv && arr) begin
        arv <= 1'b0;
        rr <= 1'b1;
      end
    end
    rr <= 1'b0;
    d = rdat;
    check("rresp", rresp, er);
  endtask : reg_rd
  function automatic logic [31:0] ctl(input logic [3:0] ws, input logic [1:0] a, b,
                                      input logic [2:0] cs);
    return {21'h0, cs, b, a, ws};
  endfunction : ctl
  task automatic start(input logic [3:0] ws, input logic [1:0] a, b, input logic [2:0] cs,
                       input logic [31:0] ca, cb, ct);
    reg_wr(REG_CTRL, ctl(ws, a, b, CS_STOP));
    reg_wr(REG_CMPA, ca);
    reg_wr(REG_CMPB, cb);
    reg_wr(REG_CAPTOP, ct);
    reg_wr(REG_COUNT, 32'h0);
    reg_wr(REG_FLAGS, 32'hf);
    reg_wr(REG_CTRL, ctl(ws, a, b, cs));
  endtask : start
  // The first period may still run on the old compare value, so the second one is kept.
  task automatic measure(input bit s, output int h, output int l);
    repeat (2) begin
      repeat (4000) begin
        @(posedge mclk);
        if ((s ? pb : pa) === 1'b0) break;
      end
      repeat (4000) begin
        @(posedge mclk);
        if ((s ? pb : pa) === 1'b1) break;
      end
      h = 1;
      l = 0;
      repeat (4000) begin
        @(posedge mclk);
        if ((s ? pb : pa) !== 1'b1) break;
        h++;
      end
      repeat (4000) begin
        l++;
        @(posedge mclk);
        if ((s ? pb : pa) === 1'b1) break;
      end
    end
  endtask : measure
  // ========================================
  // Test sequence
  initial begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge mclk);
    check("reset_pins", {pa, pa_oe, pb, pb_oe}, 4'h0);
    arst_n <= 1'b1;
    @(posedge mclk);
    reg_rd(REG_CTRL, v);
    check("ctrl_rst", v, 32'h0);
    reg_rd(REG_PORT, v);
    check("port_rst", v, 32'h0);
    reg_wr(8'h40, 32'h1, RESP_SLVERR);
    reg_rd(8'h40, v, RESP_SLVERR);
    check("unmapped", v, 32'h0);
    reg_wr(REG_PORT, 32'h5);
    repeat (2) @(posedge mclk);
    check("port_a", {pa, pa_oe}, 2'b11);
    reg_wr(REG_PORT, 32'h3);
    repeat (2) @(posedge mclk);
    check("port_oe", {pa, pa_oe, pb_oe}, 3'b011);
    // Both TOP sources and every prescaler step are run; a TOP of 1 keeps slow steps short.
    for (int i = 0; i < 5; i++) begin
      c = (i < 2) ? 32'h3 : 32'h1;
      e = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : (i == 3) ? 256 : 1024;
      start(i[0] ? WS_CTC_CAP : WS_CTC_CMPA, 2'd1, 2'd0, 3'(i + 1), c, 32'h0, c);
      measure(0, hi, lo);
      check("ctc_hi", hi, e * (c + 1));
      check("ctc_lo", lo, e * (c + 1));
      reg_rd(REG_FLAGS, v);
      check("ctc_flags", v & 32'hb, i[0] ? 32'ha : 32'h2);
    end
    for (int i = 0; i < 2; i++) begin
      start(i ? WS_FAST_CAP : WS_CTC_CMPA, 2'd0, 2'd0, CS_STOP, 32'h5, 32'h0, 32'h5);
      reg_wr(REG_COUNT, 32'hfff0);
      reg_wr(REG_CTRL, ctl(i ? WS_FAST_CAP : WS_CTC_CMPA, 2'd0, 2'd0, CS_DIV1));
      reg_rd(REG_COUNT, v);
      check("miss_top", v[15:4], 32'hfff);
      repeat (30) @(posedge mclk);
      reg_rd(REG_FLAGS, v);
      check("wrap_flags", v & 32'h9, i ? 32'h9 : 32'h1);
    end
    for (int i = 0; i < 3; i++) begin
      c = i == 0 ? TOP_8B : i == 1 ? TOP_9B : TOP_10B;
      start(WS_FAST_8B + 4'(i), 2'd0, 2'd2, CS_DIV1, 32'h0, 32'h1210, 32'h0);
      reg_rd(REG_CMPB, v);
      check("cmp_mask", v, 32'h1210 & c);
      measure(1, hi, lo);
      check("fix_hi", hi, c - (32'h1210 & c));
      check("fix_lo", lo, (32'h1210 & c) + 1);
    end
    for (int k = 0; k < 8; k++) begin
      c = k[0] ? 32'h3 : 32'h0;
      start(k[2] ? WS_FAST_CMPA : WS_FAST_CAP, {1'b0, k[2]}, {1'b1, k[1]}, CS_DIV1,
            32'h9, c, 32'h9);
      measure(1, hi, lo);
      check("pwm_hi", hi, k[1] ? c + 1 : 9 - c);
      check("pwm_lo", lo, k[1] ? 9 - c : c + 1);
      reg_rd(REG_FLAGS, v);
      check("pwm_flags", v, k[2] ? 32'h7 : 32'hf);
      if (k[2]) begin
        measure(0, hi, lo);
        check("tgl_hi", hi, 32'd10);
        check("tgl_lo", lo, 32'd10);
      end
    end
    for (int k = 0; k < 2; k++) begin
      start(WS_FAST_CAP, 2'd0, k ? 2'd3 : 2'd2, CS_DIV1, 32'h9, 32'h9, 32'h9);
      repeat (25) @(posedge mclk);
      e = 0;
      repeat (20) begin
        @(posedge mclk);
        e += (pb === 1'b1);
      end
      check("pwm_top", e, k ? 0 : 20);
    end
    reg_wr(REG_CTRL, ctl(WS_FAST_CAP, 2'd0, 2'd0, CS_STOP));
    reg_rd(REG_COUNT, c);
    repeat (10) @(posedge mclk);
    reg_rd(REG_COUNT, v);
    check("count_hold", v, c);
    wrap_up();
  end
endmodule : tcfp_tb

// *** design/tcfp_chan.sv ***
// One compare channel: buffered compare value, match detect and waveform state.
`timescale 1ns/1ps
module tcfp_chan (
  input wire logic mclk,
  input wire logic arst_n,
  tcfp_chan_if.chan ch
);
  import tcfp_pkg::*;

  typedef struct packed {
    tcfp_cnt_type active;
    tcfp_cnt_type buffered;
    logic         wave;
  } tcfp_chan_state_type;

  tcfp_chan_state_type s_r;
  tcfp_chan_state_type s_nxt;

  // A value above TOP is reached, and so matches, only when the counter has been left above TOP.
  assign ch.match = ch.tick && !ch.block && (ch.count == s_r.active);
  assign ch.active = s_r.active;
  assign ch.buffered = s_r.buffered;
  assign ch.wave = s_r.wave;

  always_comb begin
    s_nxt = s_r;
    if (ch.wr) begin
      s_nxt.buffered = ch.wdata;
      if (!ch.pwm) begin
        s_nxt.active = ch.wdata;
      end
    end
    if (ch.pwm && ch.fast && ch.top_match) begin
      s_nxt.active = s_r.buffered;
    end
    // A match beats the wrap, which keeps a non-inverting or inverting output fixed when compare equals TOP.
    if (ch.fast) begin
      if (ch.match) begin
        case (ch.action)
          ACT_TOGGLE: s_nxt.wave = ch.toggle_ok ? !s_r.wave : s_r.wave;
          ACT_NONINV: s_nxt.wave = 1'b1;
          ACT_INV:    s_nxt.wave = 1'b0;
          default:    s_nxt.wave = s_r.wave;
        endcase
      end else if (ch.top_match) begin
        case (ch.action)
          ACT_NONINV: s_nxt.wave = 1'b0;
          ACT_INV:    s_nxt.wave = 1'b1;
          default:    s_nxt.wave = s_r.wave;
        endcase
      end
    end else if (ch.match) begin
      case (ch.action)
        ACT_TOGGLE: s_nxt.wave = !s_r.wave;
        ACT_NONINV: s_nxt.wave = 1'b0;
        ACT_INV:    s_nxt.wave = 1'b1;
        default:    s_nxt.wave = s_r.wave;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{active: CNT_ZERO, buffered: CNT_ZERO, wave: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_BUF_LOAD: assert property (ch.pwm && ch.fast && ch.top_match
    |=> s_r.active == $past(s_r.buffered)) else $error("Buffered compare not loaded at TOP.");
  AST_DIRECT_WR: assert property (ch.wr && !ch.pwm
    |=> s_r.active == $past(ch.wdata)) else $error("Direct compare write lost.");
  AST_NONINV_SET: assert property (ch.fast && ch.match && ch.action == ACT_NONINV
    |=> s_r.wave) else $error("Non-inverting output not set on match.");
  AST_TOGGLE: assert property (ch.match && ch.action == ACT_TOGGLE
    && (!ch.fast || ch.toggle_ok) |=> s_r.wave != $past(s_r.wave))
    else $error("Toggle output did not change on match.");
  AST_NO_ACTION: assert property (ch.action == ACT_NONE |=> $stable(s_r.wave))
    else $error("Waveform moved with no output action.");
endmodule : tcfp_chan

// *** design/tcfp_chan_if.sv ***
// Signals between the timer core and one compare channel.
`timescale 1ns/1ps
interface tcfp_chan_if;
  import tcfp_pkg::*;
  logic            tick;
  tcfp_cnt_type    count;
  logic            block;
  logic            top_match;
  logic            fast;
  logic            pwm;
  logic            toggle_ok;
  tcfp_action_type action;
  logic            wr;
  tcfp_cnt_type    wdata;
  tcfp_cnt_type    active;
  tcfp_cnt_type    buffered;
  logic            wave;
  logic            match;
  modport timer (output tick, count, block, top_match, fast, pwm, toggle_ok, action, wr,
                 wdata, input active, buffered, wave, match);
  modport chan (input tick, count, block, top_match, fast, pwm, toggle_ok, action, wr,
                wdata, output active, buffered, wave, match);
endinterface : tcfp_chan_if

// *** design/tcfp_pkg.sv ***
// Constants, register map and types of the 16-bit timer CLEAR_ON_MATCH_MODE and fast PWM block.
package tcfp_pkg;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  typedef logic [15:0] tcfp_cnt_type;
  localparam tcfp_cnt_type CNT_ZERO = 16'h0000;
  localparam tcfp_cnt_type CNT_ONE  = 16'h0001;
  localparam tcfp_cnt_type CNT_MAX  = 16'hffff;
  localparam tcfp_cnt_type TOP_8B   = 16'h00ff;
  localparam tcfp_cnt_type TOP_9B   = 16'h01ff;
  localparam tcfp_cnt_type TOP_10B  = 16'h03ff;
  localparam int WS_W = 4;
  localparam logic [3:0] WS_NORMAL    = 4'h0;
  localparam logic [3:0] WS_CTC_CMPA  = 4'h4;
  localparam logic [3:0] WS_FAST_8B   = 4'h5;
  localparam logic [3:0] WS_FAST_9B   = 4'h6;
  localparam logic [3:0] WS_FAST_10B  = 4'h7;
  localparam logic [3:0] WS_CTC_CAP   = 4'hc;
  localparam logic [3:0] WS_RESERVED  = 4'hd;
  localparam logic [3:0] WS_FAST_CAP  = 4'he;
  localparam logic [3:0] WS_FAST_CMPA = 4'hf;
  localparam int ACT_W = 2;
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_NONINV = 2'b10,
    ACT_INV    = 2'b11
  } tcfp_action_type;
  localparam int CS_W = 3;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int PRESC_W = 10;
  localparam logic [9:0] PRESC_ZERO    = 10'h000;
  localparam logic [9:0] PRESC_ONE     = 10'h001;
  localparam logic [9:0] LAST_DIV8     = 10'h007;
  localparam logic [9:0] LAST_DIV64    = 10'h03f;
  localparam logic [9:0] LAST_DIV256   = 10'h0ff;
  localparam logic [9:0] LAST_DIV1024  = 10'h3ff;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COUNT  = 8'h04;
  localparam logic [7:0] REG_CMPA   = 8'h08;
  localparam logic [7:0] REG_CMPB   = 8'h0c;
  localparam logic [7:0] REG_CAPTOP = 8'h10;
  localparam logic [7:0] REG_FLAGS  = 8'h14;
  localparam logic [7:0] REG_PORT   = 8'h18;
  localparam int CTRL_W = 11;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam int CTRL_WS_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int FLG_W = 4;
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAP = 3;
  localparam int PORT_W = 4;
  localparam int PORT_DIR_A = 0;
  localparam int PORT_DIR_B = 1;
  localparam int PORT_DAT_A = 2;
  localparam int PORT_DAT_B = 3;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tcfp_pkg

// *** design/tcfp_top.sv ***
// Top of the 16-bit timer CLEAR_ON_MATCH_MODE and fast PWM block with its AXI4-Lite register slave.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
module tcfp_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                            mclk,
  input  wire logic                            arst_n,
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [tcfp_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [tcfp_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [ADDR_W-1:0]               s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [tcfp_pkg::AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic                                 wave_out_a,
  output logic                                 wave_out_a_oe,
  output logic                                 wave_out_b,
  output logic                                 wave_out_b_oe
);
  import tcfp_pkg::*;

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_check
    $error("ADDR_W must lie between 5 and 32.");
  end

  typedef struct packed {
    logic [CTRL_W-1:0]     ctrl;
    tcfp_cnt_type          count;
    tcfp_cnt_type          captop;
    logic [FLG_W-1:0]      flags;
    logic [PORT_W-1:0]     port;
    logic [PRESC_W-1:0]    presc;
    logic                  block;
    logic                  awready;
    logic                  aw_got;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  wready;
    logic                  w_got;
    logic [AXI_DATA_W-1:0] w_data;
    logic [AXI_STRB_W-1:0] w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [AXI_DATA_W-1:0] rdata;
    logic                  pin_a;
    logic                  pin_a_oe;
    logic                  pin_b;
    logic                  pin_b_oe;
  } tcfp_top_state_type;

  tcfp_top_state_type s_r;
  tcfp_top_state_type s_nxt;

  tcfp_chan_if cha ();
  tcfp_chan_if chb ();

  logic [WS_W-1:0]       ws;
  logic [CS_W-1:0]       cs;
  tcfp_action_type       act_a;
  tcfp_action_type       act_b;
  logic                  is_ctc;
  logic                  is_fast;
  logic                  is_pwm;
  logic                  tick;
  logic                  top_match;
  tcfp_cnt_type          top_v;
  tcfp_cnt_type          wmask;
  logic [PRESC_W-1:0]    presc_last;
  logic                  wr_go;
  logic [AXI_DATA_W-1:0] strb_mask;
  logic [AXI_DATA_W:0]   wr_cur;
  logic [AXI_DATA_W:0]   rd_cur;
  logic [AXI_DATA_W-1:0] wr_val;
  logic [ADDR_W-1:0]     wr_addr;
  logic                  cnt_wr;
  logic                  cmpa_wr;
  logic                  cmpb_wr;
  logic [FLG_W-1:0]      flag_clr;
  logic [FLG_W-1:0]      flag_set;

  // ==========================================================================
  // Register read decode
  function automatic logic [AXI_DATA_W:0] reg_rd(input logic [ADDR_W-1:0] a);
    logic [AXI_DATA_W:0] r;
    r = '0;
    r[AXI_DATA_W] = 1'b1;
    case ({a[ADDR_W-1:2], 2'b00})
      ADDR_W'(REG_CTRL):   r[CTRL_W-1:0] = s_r.ctrl;
      ADDR_W'(REG_COUNT):  r[15:0] = s_r.count;
      ADDR_W'(REG_CMPA):   r[15:0] = cha.buffered;
      ADDR_W'(REG_CMPB):   r[15:0] = chb.buffered;
      ADDR_W'(REG_CAPTOP): r[15:0] = s_r.captop;
      ADDR_W'(REG_FLAGS):  r[FLG_W-1:0] = s_r.flags;
      ADDR_W'(REG_PORT):   r[PORT_W+1:0] = {chb.wave, cha.wave, s_r.port};
      default:             r[AXI_DATA_W] = 1'b0;
    endcase
    return r;
  endfunction : reg_rd

  // ==========================================================================
  // Mode and write decode
  always_comb begin
    ws = s_r.ctrl[CTRL_WS_LSB +: WS_W];
    cs = s_r.ctrl[CTRL_CS_LSB +: CS_W];
    act_a = tcfp_action_type'(s_r.ctrl[CTRL_ACTA_LSB +: ACT_W]);
    act_b = tcfp_action_type'(s_r.ctrl[CTRL_ACTB_LSB +: ACT_W]);
    is_ctc = (ws == WS_CTC_CMPA) || (ws == WS_CTC_CAP);
    is_fast = (ws == WS_FAST_8B) || (ws == WS_FAST_9B) || (ws == WS_FAST_10B)
           || (ws == WS_FAST_CAP) || (ws == WS_FAST_CMPA);
    is_pwm = !((ws == WS_NORMAL) || is_ctc || (ws == WS_RESERVED));
    case (ws)
      WS_CTC_CMPA, WS_FAST_CMPA: top_v = cha.active;
      WS_CTC_CAP, WS_FAST_CAP:   top_v = s_r.captop;
      WS_FAST_8B:                top_v = TOP_8B;
      WS_FAST_9B:                top_v = TOP_9B;
      WS_FAST_10B:               top_v = TOP_10B;
      default:                   top_v = CNT_MAX;
    endcase
    case (ws)
      WS_FAST_8B:  wmask = TOP_8B;
      WS_FAST_9B:  wmask = TOP_9B;
      WS_FAST_10B: wmask = TOP_10B;
      default:     wmask = CNT_MAX;
    endcase
    case (cs)
      CS_DIV8:    presc_last = LAST_DIV8;
      CS_DIV64:   presc_last = LAST_DIV64;
      CS_DIV256:  presc_last = LAST_DIV256;
      CS_DIV1024: presc_last = LAST_DIV1024;
      default:    presc_last = PRESC_ZERO;
    endcase
    tick = (cs != CS_STOP) && (cs <= CS_DIV1024) && (s_r.presc == presc_last);
    // Exact equality only: a TOP written below the count is passed by.
    top_match = tick && !s_r.block && (is_ctc || is_fast) && (s_r.count == top_v);
    for (int i = 0; i < AXI_STRB_W; i++) begin
      strb_mask[8*i +: 8] = {8{s_r.w_strb[i]}};
    end
    wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_addr = {s_r.aw_addr[ADDR_W-1:2], 2'b00};
    wr_cur = reg_rd(s_r.aw_addr);
    wr_val = (wr_cur[AXI_DATA_W-1:0] & ~strb_mask) | (s_r.w_data & strb_mask);
    cnt_wr = wr_go && (wr_addr == ADDR_W'(REG_COUNT));
    cmpa_wr = wr_go && (wr_addr == ADDR_W'(REG_CMPA));
    cmpb_wr = wr_go && (wr_addr == ADDR_W'(REG_CMPB));
    flag_clr = (wr_go && (wr_addr == ADDR_W'(REG_FLAGS)))
             ? (s_r.w_data[FLG_W-1:0] & strb_mask[FLG_W-1:0]) : '0;
    flag_set = '0;
    flag_set[FLG_OVF] = is_fast ? top_match
                                : (tick && (s_r.count == CNT_MAX));
    flag_set[FLG_CMPA] = cha.match;
    flag_set[FLG_CMPB] = chb.match;
    flag_set[FLG_CAP] = top_match && ((ws == WS_CTC_CAP) || (ws == WS_FAST_CAP));
    rd_cur = reg_rd(s_axi_araddr);
  end

  assign cha.tick = tick;
  assign cha.count = s_r.count;
  assign cha.block = s_r.block;
  assign cha.top_match = top_match;
  assign cha.fast = is_fast;
  assign cha.pwm = is_pwm;
  assign cha.toggle_ok = (ws == WS_FAST_CMPA);
  assign cha.action = act_a;
  assign cha.wr = cmpa_wr;
  assign cha.wdata = wr_val[15:0] & wmask;
  assign chb.tick = tick;
  assign chb.count = s_r.count;
  assign chb.block = s_r.block;
  assign chb.top_match = top_match;
  assign chb.fast = is_fast;
  assign chb.pwm = is_pwm;
  assign chb.toggle_ok = 1'b0;
  assign chb.action = act_b;
  assign chb.wr = cmpb_wr;
  assign chb.wdata = wr_val[15:0] & wmask;

  tcfp_chan u_chan_a (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ch     (cha.chan)
  );

  tcfp_chan u_chan_b (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ch     (chb.chan)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.presc = ((cs == CS_STOP) || (s_r.presc == presc_last))
                ? PRESC_ZERO : s_r.presc + PRESC_ONE;
    // A counter write blocks every match on the next timer tick.
    if (cnt_wr) begin
      s_nxt.count = wr_val[15:0];
      s_nxt.block = 1'b1;
    end else if (tick) begin
      s_nxt.block = 1'b0;
      s_nxt.count = top_match ? CNT_ZERO : s_r.count + CNT_ONE;
    end
    s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_cur[AXI_DATA_W] ? RESP_OKAY : RESP_SLVERR;
      case (wr_addr)
        ADDR_W'(REG_CTRL):   s_nxt.ctrl = wr_val[CTRL_W-1:0];
        ADDR_W'(REG_CAPTOP): s_nxt.captop = wr_val[15:0];
        ADDR_W'(REG_PORT):   s_nxt.port = wr_val[PORT_W-1:0];
        default:             s_nxt.port = s_r.port;
      endcase
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_cur[AXI_DATA_W-1:0];
      s_nxt.rresp = rd_cur[AXI_DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
    s_nxt.pin_a = (act_a != ACT_NONE) ? cha.wave : s_r.port[PORT_DAT_A];
    s_nxt.pin_b = (act_b != ACT_NONE) ? chb.wave : s_r.port[PORT_DAT_B];
    s_nxt.pin_a_oe = s_r.port[PORT_DIR_A];
    s_nxt.pin_b_oe = s_r.port[PORT_DIR_B];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign wave_out_a = s_r.pin_a;
  assign wave_out_a_oe = s_r.pin_a_oe;
  assign wave_out_b = s_r.pin_b;
  assign wave_out_b_oe = s_r.pin_b_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_fast_top;
    top_match && is_fast && !cnt_wr;
  endsequence
  sequence s_restart;
    (s_r.count == CNT_ZERO) && s_r.flags[FLG_OVF];
  endsequence

  AST_FAST_WRAP: assert property (s_fast_top |=> s_restart)
    else $error("Fast PWM did not clear with overflow at TOP.");
  AST_CTC_CLEAR: assert property (tick && is_ctc && !s_r.block && !cnt_wr
    && s_r.count == top_v |=> s_r.count == CNT_ZERO) else $error("No clear at TOP.");
  AST_CAP_FLAG: assert property (top_match && ws == WS_CTC_CAP |=> s_r.flags[FLG_CAP])
    else $error("Capture flag missing at TOP.");
  AST_MISS_TOP: assert property (tick && is_ctc && !cnt_wr && s_r.count > top_v
    && s_r.count != CNT_MAX |=> s_r.count == $past(s_r.count) + CNT_ONE)
    else $error("Counter did not run past a low TOP.");
  AST_OVF_ROLL: assert property (tick && !is_fast && !cnt_wr
    && s_r.count == CNT_MAX |=> s_r.count == CNT_ZERO && s_r.flags[FLG_OVF])
    else $error("Overflow flag missing at roll.");
  AST_HOLD: assert property (!tick && !cnt_wr |=> $stable(s_r.count))
    else $error("Counter moved without a tick.");
  AST_MASK: assert property (cha.wr && ws == WS_FAST_8B |-> (cha.wdata & ~TOP_8B) == '0)
    else $error("Compare bits above resolution not cleared.");
  AST_PIN_A: assert property (act_a != ACT_NONE |=> wave_out_a == $past(cha.wave))
    else $error("Pin A not driven by the waveform.");
  AST_CMPA_FLAG: assert property (cha.match |=> s_r.flags[FLG_CMPA])
    else $error("Compare A flag missing on match.");
endmodule : tcfp_top
